// ===== hbc_bridge_ctrl.sv
// Function
// R1: inputs LL A source B sink, LH reverse, HL brake, HH all off
// R2: sink low on, source high on, high impedance both off
// R3: never turn on a transistor while its complement is still active
// R4: all transistors off during supply lockout; analog hysteresis upstream
// R5: fault persisting 50 us turns all stages off, pulls flag low
// R6: changing direction inputs clears the latched flag; host toggles
// R7: output short to ground with high side on is a fault
// R8: output short to supply with low side on is a fault
// R9: low-side overload indication is a fault
// R10: overtemperature turns all four stages off and sets flag after delay
// R11: in HH, A at supply and B at ground for 50 us latches flag
// R12: flag is open-drain active low, pulled low while fault latched
// R13: load short between outputs is not cleared by input toggling
// R14: fault delay restarts when the indication drops early
// R15: reset clears latch, releases flag; inputs synchronised before decode
`timescale 1ns/1ns
module hbc_bridge_ctrl
   import hbc_pkg::*;
#(
   parameter int DELAY_CYC = FAULT_DELAY_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // direction pins
   input wire logic dir_ctrl_a_in,
   input wire logic dir_ctrl_b_in,
   // analog indications
   input wire logic supply_lockout_in,
   input wire hbc_sense_t sense_in,
   // transistor monitors (1 = conducting)
   input wire hbc_leg_t mon_a_in,
   input wire hbc_leg_t mon_b_in,
   // gate drives
   output hbc_leg_t bridge_out_a_out,
   output hbc_leg_t bridge_out_b_out,
   // open-drain fault flag, oe low drives the pin
   output logic fault_flag_n_out,
   output logic fault_flag_n_oe_out
);
   logic dir_a_q, dir_b_q, lock_q;
   logic chg_a, chg_b, chg_lock;
   logic [DLY_W-1:0] cnt_q, cnt_d;
   hbc_state_t st_q, st_d;
   logic hold_q, hold_d;
   hbc_leg_t a_q, b_q;
   logic oe_q, oe_d;
   hbc_leg_t want_a, want_b;
   logic fault_now, dir_chg;

   // pin synchronisers
   hbc_sync #(
      .STAGES(SYNC_STAGES),
      .RST_VAL(1'b0)
   ) u_sync_a (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pin_in(dir_ctrl_a_in),
      .level_out(dir_a_q), // see R15
      .chg_out(chg_a)
   );

   hbc_sync #(
      .STAGES(SYNC_STAGES),
      .RST_VAL(1'b0)
   ) u_sync_b (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pin_in(dir_ctrl_b_in),
      .level_out(dir_b_q),
      .chg_out(chg_b)
   );

   // lockout assumed until the supply is seen good
   hbc_sync #(
      .STAGES(SYNC_STAGES),
      .RST_VAL(1'b1)
   ) u_sync_lock (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pin_in(supply_lockout_in),
      .level_out(lock_q),
      .chg_out(chg_lock)
   );

   // fault detection and delay
   always_comb begin
      fault_now = (sense_in.short_gnd_a & a_q.high_on) // see R7
         | (sense_in.short_gnd_b & b_q.high_on)
         | (sense_in.short_sup_a & a_q.low_on) // see R8
         | (sense_in.short_sup_b & b_q.low_on)
         | sense_in.overload // see R9
         | sense_in.overtemp // see R10
         | sense_in.load_short
         | (dir_a_q & dir_b_q & sense_in.open_a_high
            & sense_in.open_b_low); // see R11
      dir_chg = chg_a | chg_b;
      st_d = st_q;
      cnt_d = cnt_q;
      hold_d = hold_q;
      case (st_q)
         ST_RUN: begin
            cnt_d = '0;
            if (fault_now) begin
               st_d = ST_WAIT;
               cnt_d = DLY_W'(1);
            end
         end
         ST_WAIT: begin
            if (!fault_now) begin
               st_d = ST_RUN; // see R14
               cnt_d = '0;
            end else if (cnt_q >= DLY_W'(DELAY_CYC - 1)) begin
               st_d = ST_FAULT; // see R5
               hold_d = sense_in.load_short; // see R13
            end else begin
               cnt_d = cnt_q + DLY_W'(1);
            end
         end
         ST_FAULT: begin
            if (dir_chg && !hold_q) begin
               st_d = ST_RUN; // see R6
               cnt_d = '0;
            end
         end
         default: begin
            st_d = ST_RUN;
            cnt_d = '0;
            hold_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_q <= ST_RUN; // see R15
         cnt_q <= '0;
         hold_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         hold_q <= hold_d;
      end
   end

   // direction decode and gate drive
   always_comb begin
      case ({dir_a_q, dir_b_q}) // see R1
         2'b00: begin
            want_a = '{high_on: 1'b1, low_on: 1'b0}; // see R2
            want_b = '{high_on: 1'b0, low_on: 1'b1};
         end
         2'b01: begin
            want_a = '{high_on: 1'b0, low_on: 1'b1};
            want_b = '{high_on: 1'b1, low_on: 1'b0};
         end
         2'b10: begin
            want_a = '{high_on: 1'b0, low_on: 1'b1};
            want_b = '{high_on: 1'b0, low_on: 1'b1};
         end
         default: begin
            want_a = '0;
            want_b = '0;
         end
      endcase
      // gates drop on the same edge that pulls the flag
      if (lock_q || st_d == ST_FAULT) begin // see R5
         want_a = '0; // see R4
         want_b = '0; // see R10
      end
      oe_d = ~(st_d == ST_FAULT); // see R12
   end

   // break-before-make per half-bridge
   hbc_leg_drv u_leg_a (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .want_in(want_a),
      .mon_in(mon_a_in),
      .gate_out(a_q)
   );

   hbc_leg_drv u_leg_b (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .want_in(want_b),
      .mon_in(mon_b_in),
      .gate_out(b_q)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         oe_q <= 1'b1;
      end else begin
         oe_q <= oe_d;
      end
   end

   assign bridge_out_a_out = a_q;
   assign bridge_out_b_out = b_q;
   assign fault_flag_n_out = 1'b0;
   assign fault_flag_n_oe_out = oe_q;
endmodule // hbc_bridge_ctrl

module hbc_sync
   import hbc_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES,
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // raw pin
   input wire logic pin_in,
   // filtered level and its change strobe
   output logic level_out,
   output logic chg_out
);
   logic [STAGES-1:0] pipe_q, pipe_d;
   logic level_q, level_d;

   // a change counts once the last two stages agree
   always_comb begin
      pipe_d = {pipe_q[STAGES-2:0], pin_in};
      level_d = level_q;
      if (pipe_q[STAGES-2] == pipe_q[STAGES-1]) begin
         level_d = pipe_q[STAGES-1];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pipe_q <= {STAGES{RST_VAL}};
         level_q <= RST_VAL;
      end else begin
         pipe_q <= pipe_d;
         level_q <= level_d;
      end
   end

   assign level_out = level_q;
   assign chg_out = level_d != level_q;
endmodule // hbc_sync

module hbc_leg_drv
   import hbc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // requested and sensed transistor states
   input wire hbc_leg_t want_in,
   input wire hbc_leg_t mon_in,
   // registered gate enables
   output hbc_leg_t gate_out
);
   hbc_leg_t gate_q, gate_d;

   // wait for the complement to be off, as driven and as sensed
   always_comb begin
      gate_d.high_on = want_in.high_on & ~mon_in.low_on
         & ~gate_q.low_on; // see R3
      gate_d.low_on = want_in.low_on & ~mon_in.high_on
         & ~gate_q.high_on;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         gate_q <= '0;
      end else begin
         gate_q <= gate_d;
      end
   end

   assign gate_out = gate_q;
endmodule // hbc_leg_drv

// ===== hbc_pkg.sv
package hbc_pkg;
   // timebase
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int FAULT_DELAY_US = 50;
   localparam int FAULT_DELAY_CYC = (FAULT_DELAY_US * (CLK_FREQ_HZ / 1_000_000)) < 1 ? 1 :
      FAULT_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int DLY_W = 11;
   localparam int SYNC_STAGES = 3;

   // transistor gates of one half-bridge
   typedef struct packed {
      logic high_on;
      logic low_on;
   } hbc_leg_t;

   // analog sense indications
   typedef struct packed {
      logic short_gnd_a;
      logic short_gnd_b;
      logic short_sup_a;
      logic short_sup_b;
      logic overload;
      logic overtemp;
      logic load_short;
      logic open_a_high;
      logic open_b_low;
   } hbc_sense_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_WAIT = 3'b010,
      ST_FAULT = 3'b100
   } hbc_state_t;
endpackage : hbc_pkg

// ===== hbc_far_mdl.sv
`timescale 1ns/1ns
module hbc_far_mdl
   import hbc_pkg::*;
(
   // gates and flag enable
   input wire logic clk_in,
   input wire hbc_leg_t ga_in,
   input wire hbc_leg_t gb_in,
   input wire logic oe_in,
   input wire logic data_in,
   // sensed state
   output hbc_leg_t ma_out,
   output hbc_leg_t mb_out,
   output logic pin_out
);
   // transistors lag their gates
   always_ff @(posedge clk_in) begin
      ma_out <= ga_in;
      mb_out <= gb_in;
   end
   // pull-up when released
   assign pin_out = oe_in ? 1'b1 : data_in;
endmodule // hbc_far_mdl

// ===== hbc_bridge_ctrl_chk.sv
`timescale 1ns/1ns
module hbc_bridge_ctrl_chk
   import hbc_pkg::*;
#(parameter int DELAY_CYC = FAULT_DELAY_CYC)
(
   // watched ports
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic dir_ctrl_a_in,
   input wire logic dir_ctrl_b_in,
   input wire logic supply_lockout_in,
   input wire hbc_sense_t sense_in,
   input wire hbc_leg_t mon_a_in,
   input wire hbc_leg_t mon_b_in,
   input wire hbc_leg_t bridge_out_a_out,
   input wire hbc_leg_t bridge_out_b_out,
   input wire logic fault_flag_n_out,
   input wire logic fault_flag_n_oe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire [3:0] g = {bridge_out_a_out, bridge_out_b_out};
   wire [1:0] d = {dir_ctrl_a_in, dir_ctrl_b_in};
   wire oe = fault_flag_n_oe_out;
   logic [3:0] eg;
   logic [15:0] run_d, run_q;
   always_comb begin
      eg = d[1] ? {1'b0, ~d[0], 1'b0, ~d[0]} : {~d[0], d[0], d[0], ~d[0]};
      run_d = (rst_in || sense_in == '0) ? 16'h0 : run_q + 16'h1;
   end
   always_ff @(posedge clk_in) run_q <= run_d;
   property p_dec;
      ($stable(d) && !supply_lockout_in && oe)[*8] |-> g == eg;
   endproperty
   a_dec: assert property (p_dec) else $error("decode");
   property p_xa;
      $rose(bridge_out_a_out.high_on) |-> !$past(mon_a_in.low_on);
   endproperty
   a_xa: assert property (p_xa) else $error("overlap a");
   property p_xb;
      $rose(bridge_out_b_out.low_on) |-> !$past(mon_b_in.high_on);
   endproperty
   a_xb: assert property (p_xb) else $error("overlap b");
   property p_lk;
      supply_lockout_in[*6] |-> g == 4'h0;
   endproperty
   a_lk: assert property (p_lk) else $error("lockout");
   property p_fl;
      fault_flag_n_out == 1'b0;
   endproperty
   a_fl: assert property (p_fl) else $error("flag data");
   property p_sd;
      !oe |-> g == 4'h0;
   endproperty
   a_sd: assert property (p_sd) else $error("shutdown");
   property p_dl;
      $fell(oe) |-> run_q >= DELAY_CYC;
   endproperty
   a_dl: assert property (p_dl) else $error("early trip");
   property p_rs;
      disable iff (1'b0) rst_in |=> oe && g == 4'h0;
   endproperty
   a_rs: assert property (p_rs) else $error("reset");
   c_trip: cover property ($fell(oe));
   c_clr: cover property ($rose(oe));
   c_ccw: cover property (d == 2'h1 && g == 4'h6);
endmodule // hbc_bridge_ctrl_chk
bind hbc_bridge_ctrl hbc_bridge_ctrl_chk #(.DELAY_CYC(DELAY_CYC)) chk (
   .clk_in(clk_in),
   .rst_in(rst_in),
   .dir_ctrl_a_in(dir_ctrl_a_in),
   .dir_ctrl_b_in(dir_ctrl_b_in),
   .supply_lockout_in(supply_lockout_in),
   .sense_in(sense_in),
   .mon_a_in(mon_a_in),
   .mon_b_in(mon_b_in),
   .bridge_out_a_out(bridge_out_a_out),
   .bridge_out_b_out(bridge_out_b_out),
   .fault_flag_n_out(fault_flag_n_out),
   .fault_flag_n_oe_out(fault_flag_n_oe_out)
);

// ===== hbc_bridge_ctrl_tb.sv
`timescale 1ns/1ns
`define CK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module hbc_bridge_ctrl_tb;
   import hbc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic lk = 1'b0;
   logic [1:0] dir = 2'h0;
   hbc_sense_t sns = '0;
   hbc_leg_t ga, gb, ma, mb;
   logic fn, oe, pin;
   int fail_count = 0;
   int checks = 0;
   logic [5:0] rows [4] = '{6'h09, 6'h16, 6'h25, 6'h30};
   logic [10:0] fr [7] = '{11'h100, 11'h280, 11'h240, 11'h020,
      11'h410, 11'h408, 11'h603};
   always #25 clk_in = ~clk_in;
   hbc_bridge_ctrl #(.DELAY_CYC(10)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .dir_ctrl_a_in(dir[1]), .dir_ctrl_b_in(dir[0]),
      .supply_lockout_in(lk), .sense_in(sns), .mon_a_in(ma), .mon_b_in(mb),
      .bridge_out_a_out(ga), .bridge_out_b_out(gb),
      .fault_flag_n_out(fn), .fault_flag_n_oe_out(oe));
   hbc_far_mdl far (.clk_in(clk_in), .ga_in(ga), .gb_in(gb), .oe_in(oe),
      .data_in(fn), .ma_out(ma), .mb_out(mb), .pin_out(pin));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      cyc(3000);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      cyc(11);
      @(negedge clk_in);
      `CK({pin, ga, gb}, 5'h10)
      $display("reset test done");
      @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clk_in);
         dir <= rows[i][5:4];
         cyc(8);
         @(negedge clk_in);
         `CK({pin, ga, gb}, {1'b1, rows[i][3:0]})
      end
      $display("decode test done");
      foreach (fr[i]) begin
         @(posedge clk_in);
         dir <= fr[i][10:9];
         cyc(8);
         sns <= fr[i][8:0];
         cyc(5);
         sns <= '0;
         cyc(3);
         @(negedge clk_in);
         `CK(pin, 1'b1)
         @(posedge clk_in);
         sns <= fr[i][8:0];
         cyc(14);
         @(negedge clk_in);
         `CK({pin, ga, gb}, 5'h00)
         @(posedge clk_in);
         sns <= '0;
         dir <= dir ^ 2'h1;
         cyc(8);
         @(negedge clk_in);
         `CK(pin, 1'b1)
         $display("fault test %0d done", i);
      end
      @(posedge clk_in);
      sns <= 9'h004;
      cyc(14);
      sns <= '0;
      dir <= dir ^ 2'h1;
      cyc(8);
      @(negedge clk_in);
      `CK(pin, 1'b0)
      $display("load short test done");
      @(posedge clk_in);
      rst_in <= 1'b1;
      dir <= 2'h0;
      cyc(2);
      rst_in <= 1'b0;
      cyc(10);
      lk <= 1'b1;
      cyc(6);
      @(negedge clk_in);
      `CK({pin, ga, gb}, 5'h10)
      @(posedge clk_in);
      lk <= 1'b0;
      cyc(8);
      @(negedge clk_in);
      `CK({ga, gb}, 4'h9)
      $display("lockout test done");
      tally_and_finish();
   end
endmodule // hbc_bridge_ctrl_tb
